// >>> hw/ncx_pkg.sv
// Purpose: Constants for the nibble core compare/count/swap/halt executor
// Assumes: 13-bit instruction words, 4-bit data memory, AXI4-Lite register access
// Notes: Byte offsets are word aligned
package ncx_pkg;
    // Register byte offsets
    localparam logic [7:0] NCX_OFF_CTRL = 8'h00;
    localparam logic [7:0] NCX_OFF_INSN = 8'h04;
    localparam logic [7:0] NCX_OFF_REGS = 8'h08;
    localparam logic [7:0] NCX_OFF_IDX_X = 8'h0C;
    localparam logic [7:0] NCX_OFF_IDX_Y = 8'h10;
    localparam logic [7:0] NCX_OFF_SP = 8'h14;
    localparam logic [7:0] NCX_OFF_STAT = 8'h18;
    localparam logic [7:0] NCX_OFF_MADDR = 8'h1C;
    localparam logic [7:0] NCX_OFF_MDATA = 8'h20;
    // Field positions
    localparam int NCX_CTRL_IRQ_BIT = 0;
    localparam int NCX_CTRL_EXT_VALID_BIT = 1;
    localparam int NCX_CTRL_EXT_LSB = 8;
    localparam int NCX_REGS_B_LSB = 4;
    localparam int NCX_REGS_C_BIT = 8;
    localparam int NCX_REGS_Z_BIT = 9;
    localparam int NCX_SP_FLAG_LSB = 8;
    localparam int NCX_STAT_BUSY_BIT = 0;
    localparam int NCX_STAT_HALT_BIT = 1;
    localparam int NCX_STAT_EXT_BIT = 2;
    localparam int NCX_STAT_ILL_BIT = 3;
    // Opcode patterns, page bytes, response codes, memory size and states
    localparam logic [12:0] NCX_OP_DEC_SP1 = 13'h1FE0;
    localparam logic [12:0] NCX_OP_DEC_SP2 = 13'h1FE4;
    localparam logic [12:0] NCX_OP_SWAP_AB = 13'h1FF7;
    localparam logic [12:0] NCX_OP_HALT = 13'h1FFC;
    localparam logic [7:0] NCX_TOP_PAGE = 8'hFF;
    localparam logic [7:0] NCX_ZERO_PAGE = 8'h00;
    localparam logic [1:0] NCX_RESP_OK = 2'h0;
    localparam logic [1:0] NCX_RESP_ERR = 2'h2;
    localparam int NCX_MEM_WORDS = 256;
    typedef enum logic [1:0] {NCX_IDLE, NCX_FETCH, NCX_EXEC2, NCX_HALTED} ncx_state_t;
endpackage

// >>> hw/ncx_mem.sv
// Purpose: Small nibble data memory standing in for the data bus
// Assumes: Single clock, registered read
// Notes: One write and one read port
`timescale 1ns/1ns
module ncx_mem
    import ncx_pkg::*;
#(
    parameter int AW = 8,
    parameter int DW = 4
)
(
    // Clock
    input wire logic aclk,
    // Write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    // Read port
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata
);
    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge aclk)
    begin
        if (we)
        begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge aclk)
    begin
        rdata <= mem[raddr];
    end
endmodule

// >>> hw/ncx_core.sv
// Purpose: Executes compare, count, swap, stack decrement and halt instructions
// Assumes: Software loads an instruction word over AXI4-Lite, state is visible
// Notes: Every instruction takes two clocks, FETCH for the registered read, then EXEC2
//
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////////
// Contract
// - Post-increment memory compare: flags, then index step
// - Index post-increment never touches flags
// - Index byte compare uses complemented immediate
// - Short-address decrement, two cycles, C and Z
// - Radix decrement wraps within radix
// - Radix field zero means sixteen
// - Radix increment field holds sixteen minus radix
// - Radix post-increment forms step index after
// - Extension on second index uses top page
// - Stack decrement sets Z, keeps C
// - Register swap one cycle, flags kept (the core takes two, FETCH then EXEC2)
// - Register/memory swap two cycles, extendable
// - Post-increment swap ignores extension
// - Halt stops core until interrupt
// - Short-address increment, two cycles, C and Z
module ncx_core
    import ncx_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Status
    output logic halted
);
    ////////////////////////////////////////////////////////////////////////////
    ncx_state_t state_q;
    logic [3:0] a_q, b_q, mem_rd;
    logic c_q, z_q, ext_q, ill_q;
    logic [7:0] ext_byte_q, sp1_q, sp2_q, maddr_q;
    logic [15:0] x_q, y_q;
    logic [12:0] insn_q;
    logic aw_q, w_q, ar_q;
    logic [7:0] awaddr_q, araddr_q;
    logic [31:0] wdata_q;
    logic wr_go, start, mem_we;
    logic [7:0] mem_waddr, mem_raddr;
    logic [3:0] mem_wdata;

    ////////////////////////////////////////////////////////////////////////////
    // Decode
    logic use_y, is_cmpi, is_cmpi_inc, is_cmpx, is_decs, is_incs;
    logic is_rdec, is_rinc, is_radix, post_inc, is_exm, is_exm_inc, is_mem2, is_ext_ok;
    logic [15:0] idx, eff_addr;
    logic [4:0] radix;
    assign is_cmpi = (insn_q[12:6] == 7'h78) && !insn_q[4];
    assign is_cmpi_inc = (insn_q[12:6] == 7'h78) && insn_q[4];
    assign is_cmpx = (insn_q[12:9] == 4'h7);
    assign is_decs = (insn_q[12:6] == 7'h40);
    assign is_incs = (insn_q[12:6] == 7'h41);
    assign is_rdec = (insn_q[12:6] == 7'h72);
    assign is_rinc = (insn_q[12:6] == 7'h76);
    assign is_radix = is_rdec || is_rinc;
    assign is_exm = (insn_q[12:4] == 9'h10F) && insn_q[3] && !insn_q[0];
    assign is_exm_inc = (insn_q[12:4] == 9'h10F) && insn_q[3] && insn_q[0];
    assign use_y = is_cmpx ? insn_q[8] : (is_exm || is_exm_inc) ? insn_q[1] : insn_q[5];
    assign post_inc = is_cmpi_inc || (is_radix && insn_q[4]) || is_exm_inc;
    assign is_ext_ok = is_cmpi || is_exm || (is_radix && !insn_q[4]);
    assign is_mem2 = is_decs || is_incs || is_radix || is_exm || is_exm_inc;
    assign idx = use_y ? y_q : x_q;
    // Radix: decrement field is n, increment field is sixteen minus n
    assign radix = is_rinc ? (5'h10 - {1'b0, insn_q[3:0]})
                 : (insn_q[3:0] == 4'h0 ? 5'h10 : {1'b0, insn_q[3:0]});

    assign eff_addr = (is_decs || is_incs) ? {10'h000, insn_q[5:0]}
        : !(ext_q && is_ext_ok) ? idx
        : use_y ? {NCX_TOP_PAGE, ext_byte_q}
        : {NCX_ZERO_PAGE, ext_byte_q};

    ////////////////////////////////////////////////////////////////////////////
    // Arithmetic
    logic [4:0] mdiff, mres, inc_raw, dec_raw;
    logic [16:0] xdiff;
    logic [7:0] spd;
    logic [3:0] ex_reg;
    assign mdiff = {1'b0, mem_rd} - {1'b0, insn_q[3:0]};
    assign xdiff = {1'b0, idx} - {9'h000, ~insn_q[7:0]};
    assign spd = (insn_q == NCX_OP_DEC_SP1 ? sp1_q : sp2_q) - 8'h01;
    assign ex_reg = insn_q[2] ? b_q : a_q;

    assign inc_raw = {1'b0, mem_rd} + 5'h01;
    assign dec_raw = {1'b0, mem_rd} - 5'h01;
    assign mres = is_incs ? inc_raw
        : is_decs ? dec_raw
        : is_rinc ? ((inc_raw >= radix) ? 5'h10 : inc_raw)
        : !is_rdec ? 5'h00
        : (mem_rd == 4'h0) ? {1'b1, 4'(radix - 5'h01)} : dec_raw;

    ////////////////////////////////////////////////////////////////////////////
    // Memory
    assign mem_raddr = eff_addr[7:0];
    assign mem_we = (state_q == NCX_EXEC2) && is_mem2;
    assign mem_waddr = eff_addr[7:0];
    assign mem_wdata = (is_exm || is_exm_inc) ? ex_reg : mres[3:0];

    ncx_mem #(.AW(8), .DW(4)) u_mem (
        .aclk(aclk),
        .we(mem_we),
        .waddr(mem_waddr),
        .wdata(mem_wdata),
        .raddr(mem_raddr),
        .rdata(mem_rd)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Execution
    assign start = wr_go && (awaddr_q == NCX_OFF_INSN) && (state_q == NCX_IDLE);
    assign halted = (state_q == NCX_HALTED);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_q <= NCX_IDLE;
            insn_q <= 13'h0000;
            a_q <= 4'h0;
            b_q <= 4'h0;
            c_q <= 1'b0;
            z_q <= 1'b0;
            x_q <= 16'h0000;
            y_q <= 16'h0000;
            sp1_q <= 8'h00;
            sp2_q <= 8'h00;
            ext_q <= 1'b0;
            ext_byte_q <= 8'h00;
            ill_q <= 1'b0;
            maddr_q <= 8'h00;
        end
        else
        begin
            case (state_q)
                NCX_IDLE:
                begin
                    if (start)
                    begin
                        insn_q <= wdata_q[12:0];
                        state_q <= NCX_FETCH;
                    end
                    else if (wr_go)
                    begin
                        if (awaddr_q == NCX_OFF_CTRL)
                        begin
                            ext_byte_q <= wdata_q[NCX_CTRL_EXT_LSB +: 8];
                            ext_q <= wdata_q[NCX_CTRL_EXT_VALID_BIT];
                        end
                        if (awaddr_q == NCX_OFF_REGS)
                        begin
                            a_q <= wdata_q[3:0];
                            b_q <= wdata_q[NCX_REGS_B_LSB +: 4];
                            c_q <= wdata_q[NCX_REGS_C_BIT];
                            z_q <= wdata_q[NCX_REGS_Z_BIT];
                        end
                        if (awaddr_q == NCX_OFF_IDX_X) x_q <= wdata_q[15:0];
                        if (awaddr_q == NCX_OFF_IDX_Y) y_q <= wdata_q[15:0];
                        if (awaddr_q == NCX_OFF_SP)
                        begin
                            sp1_q <= wdata_q[7:0];
                            sp2_q <= wdata_q[NCX_SP_FLAG_LSB +: 8];
                        end
                        if (awaddr_q == NCX_OFF_MADDR) maddr_q <= wdata_q[7:0];
                    end
                end
                NCX_FETCH: state_q <= NCX_EXEC2; // Registered memory read in flight
                NCX_EXEC2:
                begin
                    state_q <= NCX_IDLE;
                    ext_q <= 1'b0;
                    ill_q <= 1'b0;
                    if (is_cmpi || is_cmpi_inc)
                    begin
                        c_q <= mdiff[4];
                        z_q <= (mdiff[3:0] == 4'h0);
                    end
                    else if (is_cmpx)
                    begin
                        c_q <= xdiff[16];
                        z_q <= (xdiff[15:0] == 16'h0000);
                    end
                    else if (is_decs || is_incs || is_radix)
                    begin
                        c_q <= mres[4];
                        z_q <= (mres[3:0] == 4'h0);
                    end
                    else if (insn_q == NCX_OP_DEC_SP1 || insn_q == NCX_OP_DEC_SP2)
                    begin
                        z_q <= (spd == 8'h00);
                        if (insn_q == NCX_OP_DEC_SP1) sp1_q <= spd;
                        else sp2_q <= spd;
                    end
                    else if (insn_q == NCX_OP_SWAP_AB)
                    begin
                        a_q <= b_q;
                        b_q <= a_q;
                    end
                    else if (insn_q == NCX_OP_HALT) state_q <= NCX_HALTED;
                    else if (is_exm || is_exm_inc)
                    begin
                        if (insn_q[2]) b_q <= mem_rd;
                        else a_q <= mem_rd;
                    end
                    else ill_q <= 1'b1;
                    if (post_inc)
                    begin
                        if (use_y) y_q <= y_q + 16'h0001;
                        else x_q <= x_q + 16'h0001;
                    end
                end
                NCX_HALTED:
                begin
                    if (wr_go && awaddr_q == NCX_OFF_CTRL && wdata_q[NCX_CTRL_IRQ_BIT])
                    begin
                        state_q <= NCX_IDLE;
                    end
                end
                default: state_q <= NCX_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite slave
    assign s_axi_awready = !aw_q && !s_axi_bvalid;
    assign s_axi_wready = !w_q && !s_axi_bvalid;
    assign s_axi_arready = !ar_q && !s_axi_rvalid;
    assign wr_go = aw_q && w_q && !s_axi_bvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 8'h00;
            wdata_q <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= NCX_RESP_OK;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_q <= 1'b1;
                awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_q <= 1'b1;
                wdata_q <= s_axi_wdata;
            end
            if (wr_go)
            begin
                aw_q <= 1'b0;
                w_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_q > NCX_OFF_MDATA) ? NCX_RESP_ERR : NCX_RESP_OK;
            end
            else if (s_axi_bvalid && s_axi_bready) s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ar_q <= 1'b0;
            araddr_q <= 8'h00;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= NCX_RESP_OK;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            ar_q <= 1'b1;
            araddr_q <= {s_axi_araddr[7:2], 2'b00};
        end
        else if (ar_q && !s_axi_rvalid)
        begin
            ar_q <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= NCX_RESP_OK;
            case (araddr_q)
                NCX_OFF_CTRL: s_axi_rdata <= {16'h0000, ext_byte_q, 6'h00, ext_q, 1'b0};
                NCX_OFF_INSN: s_axi_rdata <= {19'h00000, insn_q};
                NCX_OFF_REGS: s_axi_rdata <= {22'h000000, z_q, c_q, b_q, a_q};
                NCX_OFF_IDX_X: s_axi_rdata <= {16'h0000, x_q};
                NCX_OFF_IDX_Y: s_axi_rdata <= {16'h0000, y_q};
                NCX_OFF_SP: s_axi_rdata <= {16'h0000, sp2_q, sp1_q};
                NCX_OFF_STAT: s_axi_rdata <= {28'h0000000, ill_q, ext_q, halted,
                                              state_q inside {NCX_FETCH, NCX_EXEC2}};
                NCX_OFF_MADDR: s_axi_rdata <= {24'h000000, maddr_q};
                NCX_OFF_MDATA: s_axi_rdata <= {28'h0000000, mem_rd};
                default:
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= NCX_RESP_ERR;
                end
            endcase
        end
        else if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
    end
endmodule

// >>> bench/ncx_mem_model.sv
// Purpose: Shadow of the data nibbles that the bench stores
// Assumes: One clock, lookup follows the store address
// Notes: Gives expected memory values for the extension cases
`timescale 1ns/1ns
module ncx_mem_model
(
    // Clock
    input wire logic aclk,
    // Store port
    input wire logic we,
    input wire logic [7:0] addr,
    input wire logic [3:0] wdata,
    // Lookup port
    output logic [3:0] rdata
);
logic [3:0] mem_q [256];
always_ff @(posedge aclk)
begin
    if (we)
        mem_q[addr] <= wdata;
end
assign rdata = mem_q[addr];
endmodule

// >>> bench/ncx_core_sva.sv
// Purpose: Bus and halt checks on the executor ports
// Assumes: Master offers address and data together
// Notes: Bound to ncx_core
`timescale 1ns/1ns
module ncx_core_sva
    import ncx_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Status
    input wire logic halted
);
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
////////////////////////////////////////////////////////////
sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
endsequence
sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
endsequence
property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
endproperty
a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
endproperty
a_r_hold: assert property (p_r_hold) else $error("rvalid dropped early");
property p_wr_answer;
    s_wr_take |-> ##[1:3] s_axi_bvalid;
endproperty
a_wr_answer: assert property (p_wr_answer) else $error("no write response");
property p_rd_answer;
    s_rd_take |-> ##[1:3] s_axi_rvalid;
endproperty
a_rd_answer: assert property (p_rd_answer) else $error("no read response");
property p_rd_unmapped;
    s_rd_take ##0 ({s_axi_araddr[7:2], 2'b00} > NCX_OFF_MDATA)
        |-> ##[1:3] s_axi_rvalid && s_axi_rresp == NCX_RESP_ERR && s_axi_rdata == 32'h0;
endproperty
a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read accepted");
property p_wr_unmapped;
    s_wr_take ##0 ({s_axi_awaddr[7:2], 2'b00} > NCX_OFF_MDATA)
        |-> ##[1:3] s_axi_bvalid && s_axi_bresp == NCX_RESP_ERR;
endproperty
a_wr_unmapped: assert property (p_wr_unmapped) else $error("unmapped write accepted");
property p_halt_entry;
    s_wr_take ##0 (s_axi_awaddr == NCX_OFF_INSN && s_axi_wdata[12:0] == NCX_OP_HALT
        && !halted) |-> ##[1:4] halted;
endproperty
a_halt_entry: assert property (p_halt_entry) else $error("halt not entered");
property p_halt_wake;
    $fell(halted) |-> $past(s_axi_wvalid) || $past(s_axi_wvalid, 2)
        || $past(s_axi_wvalid, 3) || $past(s_axi_wvalid, 4);
endproperty
a_halt_wake: assert property (p_halt_wake) else $error("halt left unasked");
property p_rst_idle;
    $rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid && !halted;
endproperty
a_rst_idle: assert property (p_rst_idle) else $error("outputs busy after reset");
endmodule
bind ncx_core ncx_core_sva u_sva (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .halted);

// >>> bench/testbench.sv
// Purpose: Self-checking bench for the nibble executor
// Assumes: Memory is preloaded by register/memory swaps
// Notes: Reset checks first, then table rows, then hand-written cases
`timescale 1ns/1ns
module testbench import ncx_pkg::*;;
typedef struct packed {logic [12:0] op; logic [15:0] x; logic [3:0] m;
    logic [11:0] r; logic [11:0] er; logic [15:0] ex; logic [3:0] em;} ncx_row_t;
logic aclk = 1'b0;
logic aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, halted;
logic [7:0] s_axi_awaddr, s_axi_araddr, mdl_addr;
logic [31:0] s_axi_wdata, s_axi_rdata, d;
logic [3:0] s_axi_wstrb, mdl_wdata, mdl_rdata;
logic [1:0] s_axi_bresp, s_axi_rresp, rs;
logic mdl_we;
int mismatches = 0;
int samples_checked = 0;
ncx_row_t rows [12] = '{
    '{13'h1E15, 16'h00FF, 4'h3, 12'h273, 12'h173, 16'h0100, 4'h3},
    '{13'h0EBD, 16'h0042, 4'h9, 12'h173, 12'h273, 16'h0042, 4'h9},
    '{13'h1005, 16'h0005, 4'h0, 12'h200, 12'h100, 16'h0005, 4'hF},
    '{13'h107F, 16'h003F, 4'hF, 12'h000, 12'h300, 16'h003F, 4'h0},
    '{13'h1C8A, 16'h0020, 4'h0, 12'h000, 12'h100, 16'h0020, 4'h9},
    '{13'h1C80, 16'h0020, 4'h1, 12'h100, 12'h200, 16'h0020, 4'h0},
    '{13'h1D86, 16'h0020, 4'h9, 12'h000, 12'h300, 16'h0020, 4'h0},
    '{13'h1D90, 16'h0021, 4'h7, 12'h300, 12'h000, 16'h0022, 4'h8},
    '{13'h1C93, 16'h0022, 4'h2, 12'h300, 12'h000, 16'h0023, 4'h1},
    '{13'h1FF7, 16'h0030, 4'h4, 12'h35A, 12'h3A5, 16'h0030, 4'h4},
    '{13'h10FD, 16'h0031, 4'h6, 12'h0C0, 12'h060, 16'h0032, 4'hC},
    '{13'h10F8, 16'h0033, 4'h2, 12'h20D, 12'h202, 16'h0033, 4'hD}};
ncx_core uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .halted);
ncx_mem_model mdl (.aclk, .we(mdl_we), .addr(mdl_addr), .wdata(mdl_wdata), .rdata(mdl_rdata));
always #4 aclk = ~aclk;
////////////////////////////////////////////////////////////
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
        mismatches++;
        $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
endtask
task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
endtask
task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
endtask
task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] g;
    logic [1:0] r;
    rd(a, g, r);
    chk(g, e);
endtask
task automatic exec(input logic [12:0] op);
    logic [31:0] g;
    logic [1:0] r;
    wr(NCX_OFF_INSN, {19'h0, op}, r);
    do rd(NCX_OFF_STAT, g, r); while (g[NCX_STAT_BUSY_BIT] !== 1'b0);
endtask
task automatic put(input logic [15:0] x, input logic [3:0] m);
    logic [1:0] r;
    wr(NCX_OFF_IDX_X, {16'h0, x}, r);
    wr(NCX_OFF_REGS, {28'h0, m}, r);
    exec(13'h10F8);
    mdl_addr <= x[7:0];
    mdl_wdata <= m;
    mdl_we <= 1'b1;
    @(posedge aclk);
    mdl_we <= 1'b0;
endtask
task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
        $display("Test passed");
    else
        $display("Test failed");
    $finish;
endtask
////////////////////////////////////////////////////////////
initial
begin
    #(8 * 20000);
    mismatches++;
    $display("ERROR %0t: watchdog expired", $time);
    results();
end
initial
begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {mdl_we, mdl_addr, mdl_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(NCX_OFF_REGS, 32'h0);
    rdc(NCX_OFF_STAT, 32'h0);
    chk({31'h0, halted}, 32'h0);
    $display("reset test done");
    foreach (rows[i])
    begin
        put(rows[i].x, rows[i].m);
        wr(NCX_OFF_REGS, {20'h0, rows[i].r}, rs);
        exec(rows[i].op);
        rdc(NCX_OFF_REGS, {20'h0, rows[i].er});
        rdc(NCX_OFF_IDX_X, {16'h0, rows[i].ex});
        wr(NCX_OFF_IDX_X, {16'h0, rows[i].x}, rs);
        exec(13'h10F8);
        rd(NCX_OFF_REGS, d, rs);
        chk({28'h0, d[3:0]}, {28'h0, rows[i].em});
        $display("row %0d done", i);
    end
    wr(NCX_OFF_REGS, 32'h100, rs);
    wr(NCX_OFF_SP, 32'h0001, rs);
    exec(NCX_OP_DEC_SP1);
    rdc(NCX_OFF_SP, 32'h0000);
    rdc(NCX_OFF_REGS, 32'h300);
    exec(NCX_OP_DEC_SP2);
    rdc(NCX_OFF_SP, 32'hFF00);
    rdc(NCX_OFF_REGS, 32'h100);
    $display("stack test done");
    put(16'h0011, 4'h9);
    put(16'h0077, 4'h4);
    wr(NCX_OFF_IDX_X, 32'h0011, rs);
    wr(NCX_OFF_REGS, 32'h100, rs);
    wr(NCX_OFF_CTRL, 32'h7702, rs);
    exec(13'h1E04);
    rdc(NCX_OFF_REGS, 32'h200);
    exec(13'h1E04);
    rdc(NCX_OFF_REGS, 32'h000);
    wr(NCX_OFF_IDX_Y, 32'h0011, rs);
    wr(NCX_OFF_REGS, 32'h001, rs);
    wr(NCX_OFF_CTRL, 32'h7702, rs);
    exec(13'h10FA);
    rdc(NCX_OFF_REGS, {28'h0, mdl_rdata});
    $display("extension test done");
    exec(13'h0000);
    rdc(NCX_OFF_STAT, 32'h8);
    wr(NCX_OFF_REGS, 32'h35A, rs);
    wr(NCX_OFF_INSN, {19'h0, NCX_OP_HALT}, rs);
    for (int n = 0; n < 8 && halted !== 1'b1; n++) @(posedge aclk);
    wr(NCX_OFF_INSN, {19'h0, NCX_OP_SWAP_AB}, rs);
    repeat (4) @(posedge aclk);
    chk({31'h0, halted}, 32'h1);
    wr(NCX_OFF_CTRL, 32'h1, rs);
    for (int n = 0; n < 8 && halted !== 1'b0; n++) @(posedge aclk);
    chk({31'h0, halted}, 32'h0);
    wr(NCX_OFF_CTRL, 32'h0, rs);
    rdc(NCX_OFF_REGS, 32'h35A);
    $display("halt test done");
    rd(8'h24, d, rs);
    chk({30'h0, rs}, {30'h0, NCX_RESP_ERR});
    chk(d, 32'h0);
    wr(8'h28, 32'h5, rs);
    chk({30'h0, rs}, {30'h0, NCX_RESP_ERR});
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rdc(NCX_OFF_REGS, 32'h0);
    $display("bus and reset test done");
    results();
end
endmodule
